// ---- fpc_convert_unit.sv ----
// Local design decisions: register access over AHB-Lite and the address map.
module fpc_convert_unit
    import fpc_pkg::*;
(
    input wire logic clk_sys, // core clock
    input wire logic rst_n, // async reset, active low
    input wire fpc_issue_t issueIn, // issued operation
    input wire logic [FLAG_W-1:0] otherFlags, // flag updates from other units
    output fpc_wb_t wbOut, // write-back to register file
    output logic [FLAG_W-1:0] pswFlags, // sticky exception flags
    output logic [1:0] roundMode, // status-word rounding mode
    output logic irq, // level interrupt
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response
    output logic [31:0] hrdata // ahb read data
);

    // unsigned integer to single precision under a given rounding mode
    function automatic fpc_conv_t toFloat(input logic [31:0] x, input logic [1:0] rm);
        fpc_conv_t r;
        logic [4:0] msb;
        logic [31:0] norm;
        logic [24:0] mant;
        logic grd;
        logic stk;
        logic up;
        logic [7:0] ex;
        r = '0;
        msb = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (x[i]) begin
                msb = 5'(i);
            end
        end
        norm = x << (5'h1F - msb);
        mant = {1'b0, norm[31:8]};
        grd = norm[7];
        stk = |norm[6:0];
        case (rm)
            RMODE_NEAREST: up = grd & (stk | norm[8]);
            RMODE_POS_INF: up = grd | stk;
            default: up = 1'b0; // positive values never round up toward -inf or zero
        endcase
        mant = mant + {24'h000000, up};
        ex = EXP_BIAS + {3'h0, msb} + {7'h00, mant[24]};
        if (x != 32'h00000000) begin
            r.value = {1'b0, ex, (mant[24] ? 23'h000000 : mant[22:0])};
            r.flags = (grd | stk) ? INEXACT_FLAG : 6'h00;
        end
        return r;
    endfunction

    // exceptions of a truncating single precision to unsigned conversion
    function automatic logic [FLAG_W-1:0] fixFlags(input logic [31:0] f);
        logic [7:0] ex;
        logic [22:0] frac;
        logic [23:0] mant;
        logic [7:0] sh;
        logic [23:0] lost;
        logic [FLAG_W-1:0] r;
        ex = f[30:23];
        frac = f[22:0];
        mant = {1'b1, frac};
        sh = EXP_INT_LSB - ex;
        lost = mant & ((24'h000001 << sh[4:0]) - 24'h000001);
        r = 6'h00;
        if (ex == EXP_MAX) begin
            r = INVALID_FLAG;
        end else if (ex == 8'h00) begin
            r = (frac != 23'h000000) ? FLUSH_TO_ZERO_FLAG : 6'h00;
        end else if (f[31]) begin
            r = INVALID_FLAG;
        end else if (ex >= EXP_TOO_BIG) begin
            r = INVALID_FLAG;
        end else if (ex < EXP_BIAS) begin
            r = INEXACT_FLAG;
        end else if (ex < EXP_INT_LSB) begin
            r = (lost != 24'h000000) ? INEXACT_FLAG : 6'h00;
        end
        return r;
    endfunction

    fpc_stage_t stage_q [LATENCY];
    fpc_stage_t stageIn;
    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_d;
    logic [1:0] rmode_q;
    logic [1:0] rmode_d;
    logic [IRQ_W-1:0] irqSt_q;
    logic [IRQ_W-1:0] irqSt_d;
    logic [IRQ_W-1:0] irqMask_q;
    logic [IRQ_W-1:0] irqMask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic dWrite_q;
    logic [7:0] dAddr_q;

    // issue decode
    wire logic slotOk = (issueIn.slot == SLOT_A) || (issueIn.slot == SLOT_B);
    wire logic isFix = issueIn.opcode == OP_UFIX_RZ_FLAGS;
    wire logic isFloat = issueIn.opcode == OP_UFLOAT;
    wire logic isFloatFlags = issueIn.opcode == OP_UFLOAT_FLAGS;
    wire logic opAccept = issueIn.valid && slotOk && (isFix || isFloat || isFloatFlags);
    wire logic guardOk = !issueIn.guardUsed || issueIn.guardLsb;
    // a false guard simply drops the operation: no write-back and no flag update
    wire logic opWrites = opAccept && guardOk;
    wire fpc_conv_t floatRes = toFloat(issueIn.src, rmode_q);
    wire logic [FLAG_W-1:0] fixRes = fixFlags(issueIn.src);
    wire logic [31:0] floatFlagVec = {26'h0000000, floatRes.flags};
    wire logic [31:0] fixFlagVec = {26'h0000000, fixRes};

    always_comb begin
        stageIn = '0;
        stageIn.valid = opWrites;
        stageIn.dest = issueIn.dest;
        if (isFloat) begin
            stageIn.data = floatRes.value;
            stageIn.flags = floatRes.flags;
            stageIn.setsPsw = 1'b1;
        end else if (isFloatFlags) begin
            stageIn.data = floatFlagVec;
        end else begin
            stageIn.data = fixFlagVec;
        end
    end

    // fixed latency pipe; every stage advances every cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= stageIn;
            for (int i = 1; i < LATENCY; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    wire fpc_stage_t wbStage = stage_q[LATENCY-1];
    // flag ops carry setsPsw low, so they never reach the status word
    wire logic [FLAG_W-1:0] convFlagSet = (wbStage.valid && wbStage.setsPsw)
        ? wbStage.flags : 6'h00;

    assign wbOut.valid = wbStage.valid;
    assign wbOut.dest = wbStage.dest;
    assign wbOut.data = wbStage.data;

    // ahb-lite slave: zero wait states, always OKAY
    wire logic addrPhase = hsel && hready && htrans[1];
    wire logic [7:0] aAddr = haddr[7:0];
    wire logic aRead = addrPhase && !hwrite;
    wire logic wrPsw = dWrite_q && (dAddr_q == REG_PSW);
    wire logic wrMask = dWrite_q && (dAddr_q == REG_IRQ_MASK);
    wire logic rdIrqClr = aRead && (aAddr == REG_IRQ_STATUS);
    wire logic [IRQ_W-1:0] irqEvt = {convFlagSet != 6'h00, wbStage.valid};

    // software write clears or sets flags, but a same-cycle hardware set still wins
    assign flags_d = (wrPsw ? hwdata[FLAG_W-1:0] : flags_q) | convFlagSet | otherFlags;
    assign rmode_d = wrPsw ? hwdata[RMODE_LSB+1:RMODE_LSB] : rmode_q;
    assign irqSt_d = (rdIrqClr ? 2'h0 : irqSt_q) | irqEvt;
    assign irqMask_d = wrMask ? hwdata[IRQ_W-1:0] : irqMask_q;

    always_comb begin
        rdata_d = 32'h00000000;
        if (aRead) begin
            case (aAddr)
                REG_PSW: rdata_d = {22'h000000, rmode_q, 2'h0, flags_q};
                REG_IRQ_STATUS: rdata_d = {30'h00000000, irqSt_q};
                REG_IRQ_MASK: rdata_d = {30'h00000000, irqMask_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= PSW_FLAGS_RST;
            rmode_q <= PSW_RMODE_RST;
            irqSt_q <= 2'h0;
            irqMask_q <= IRQ_MASK_RST;
        end else begin
            flags_q <= flags_d;
            rmode_q <= rmode_d;
            irqSt_q <= irqSt_d;
            irqMask_q <= irqMask_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dWrite_q <= 1'b0;
            dAddr_q <= 8'h00;
            rdata_q <= 32'h00000000;
        end else begin
            dWrite_q <= addrPhase && hwrite;
            dAddr_q <= addrPhase ? aAddr : dAddr_q;
            rdata_q <= rdata_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign pswFlags = flags_q;
    assign roundMode = rmode_q;
    assign irq = |(irqSt_q & irqMask_q);

    // checks
    sequence seqTakenTrue;
        opAccept && guardOk;
    endsequence

    sequence seqTakenFalse;
        opAccept && !guardOk;
    endsequence

    sequence seqWbAt3(logic [6:0] d);
        ##3 (wbOut.valid && wbOut.dest == d);
    endsequence

    property pLatency;
        @(posedge clk_sys) disable iff (!rst_n)
        // the actual is evaluated where the sequence uses it, so reach back to the issue cycle
        seqTakenTrue |-> seqWbAt3($past(issueIn.dest, 3));
    endproperty

    AST_LATENCY: assert property (pLatency)
        else $error("write-back not three cycles after issue");

    AST_GUARD_FALSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seqTakenFalse ##1 !opAccept [*2] |-> ##1 !wbOut.valid)
        else $error("false guard still produced a write-back");

    AST_BAD_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (issueIn.valid && !slotOk) ##1 !opAccept [*2] |-> ##1 !wbOut.valid)
        else $error("operation accepted from a wrong slot");

    AST_FLAGOP_NO_PSW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && !isFloat) ##3 (otherFlags == 6'h00 && !wrPsw)
        |=> flags_q == $past(flags_q))
        else $error("flag-reporting operation changed the status word");

    AST_PSW_SAME_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloat) |-> ##3 (wbOut.valid
        ##1 ((flags_q & $past(wbStage.flags)) == $past(wbStage.flags))))
        else $error("status flags not set with the write-back");

    AST_OR_MERGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wrPsw |=> (flags_q & $past(flags_q | otherFlags)) == $past(flags_q | otherFlags))
        else $error("flag merge lost an update");

    AST_FTZ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && issueIn.src[30:23] == 8'h00 && issueIn.src[22:0] != 23'h000000)
        |-> ##3 (wbOut.valid && wbOut.data == 32'h00000020))
        else $error("denormal source not reported as flush-to-zero");

    AST_INVALID_NAN_INF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && issueIn.src[30:23] == EXP_MAX)
        |-> ##3 (wbOut.data == 32'h00000010))
        else $error("infinity or NaN not reported invalid");

    AST_FLOAT_EXACT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloatFlags && issueIn.src == 32'h80000000)
        |-> ##3 (wbOut.valid && wbOut.data == 32'h00000000))
        else $error("exact unsigned value reported an exception");

    // every write-back must trace back to an accepted, enabled issue
    AST_WB_HAS_ISSUE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wbOut.valid |-> $past(opWrites, 3))
        else $error("write-back without a matching issue");

    AST_FIX_NEGATIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && issueIn.src[31] && issueIn.src[30:23] != 8'h00)
        |-> ##3 (wbOut.data == 32'h00000010))
        else $error("negative source not reported invalid");

    AST_FIX_TOO_BIG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && issueIn.src[30:23] >= EXP_TOO_BIG)
        |-> ##3 (wbOut.data == 32'h00000010))
        else $error("out of range source not reported invalid");

    AST_FIX_BELOW_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && !issueIn.src[31] && issueIn.src[30:23] != 8'h00
        && issueIn.src[30:23] < EXP_BIAS) |-> ##3 (wbOut.data == 32'h00000002))
        else $error("fraction below one not reported inexact");

    AST_FIX_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && issueIn.src[30:0] == 31'h00000000)
        |-> ##3 (wbOut.data == 32'h00000000))
        else $error("zero source reported an exception");

    AST_FIX_WHOLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix && !issueIn.src[31] && issueIn.src[30:23] >= EXP_INT_LSB
        && issueIn.src[30:23] < EXP_TOO_BIG) |-> ##3 (wbOut.data == 32'h00000000))
        else $error("whole number in range reported an exception");

    AST_FIX_VECTOR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFix) |-> ##3 ((wbOut.data & ~32'h00000032) == 32'h00000000))
        else $error("truncating flag vector has a stray bit");

    AST_FLAGOP_INEXACT_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloatFlags) |-> ##3 ((wbOut.data & ~32'h00000002) == 32'h00000000))
        else $error("unsigned flag vector has a stray bit");

    AST_FLAGOP_SMALL_EXACT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloatFlags && issueIn.src[31:24] == 8'h00)
        |-> ##3 (wbOut.data == 32'h00000000))
        else $error("value that fits the mantissa reported inexact");

    AST_FLOAT_SMALL_EXACT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloat && issueIn.src[31:24] == 8'h00) |-> ##3 (convFlagSet == 6'h00))
        else $error("exact conversion raised a status flag");

    AST_FLOAT_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloat && issueIn.src == 32'h00000000)
        |-> ##3 (wbOut.data == 32'h00000000))
        else $error("zero did not convert to positive zero");

    AST_FLOAT_NEAREST_TOP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloat && issueIn.src == 32'hFFFFFFFF && rmode_q == RMODE_NEAREST)
        |-> ##3 (wbOut.data == 32'h4F800000))
        else $error("largest value did not round up to nearest");

    AST_FLOAT_RZ_TOP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloat && issueIn.src == 32'hFFFFFFFF && rmode_q == RMODE_ZERO)
        |-> ##3 (wbOut.data == 32'h4F7FFFFF))
        else $error("largest value did not truncate toward zero");

    AST_FLOAT_NORMALIZED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (opWrites && isFloat && issueIn.src != 32'h00000000)
        |-> ##3 (!wbOut.data[31] && wbOut.data[30:23] >= EXP_BIAS))
        else $error("nonzero unsigned value gave a bad sign or exponent");

    // a software write lands exactly when no hardware set competes with it
    AST_PSW_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrPsw && convFlagSet == 6'h00 && otherFlags == 6'h00)
        |=> (flags_q == $past(hwdata[FLAG_W-1:0])
        && rmode_q == $past(hwdata[RMODE_LSB+1:RMODE_LSB])))
        else $error("status word write did not land");

    AST_GUARD_FALSE_NO_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seqTakenFalse ##1 !opAccept [*2] |-> ##1 (convFlagSet == 6'h00))
        else $error("false guard still raised a status flag");

endmodule

// ---- fpc_pkg.sv ----
package fpc_pkg;

    // operation codes handled by this slice
    localparam logic [7:0] OP_UFIX_RZ_FLAGS = 8'h7E;
    localparam logic [7:0] OP_UFLOAT = 8'h7F;
    localparam logic [7:0] OP_UFLOAT_FLAGS = 8'h80;

    // issue slots that may carry these operations
    localparam logic [2:0] SLOT_A = 3'h1;
    localparam logic [2:0] SLOT_B = 3'h4;

    // pipeline depth from issue to write-back
    localparam int LATENCY = 3;

    // exception flag bit positions, shared by processor_status_word and flag vectors
    localparam int FLAG_W = 6;
    localparam int INEXACT_FLAG_BIT = 1;
    localparam int INVALID_FLAG_BIT = 4;
    localparam int FLUSH_TO_ZERO_FLAG_BIT = 5;
    localparam logic [FLAG_W-1:0] INEXACT_FLAG = 6'h02;
    localparam logic [FLAG_W-1:0] INVALID_FLAG = 6'h10;
    localparam logic [FLAG_W-1:0] FLUSH_TO_ZERO_FLAG = 6'h20;

    // rounding mode field of processor_status_word
    localparam int RMODE_LSB = 8;
    localparam logic [1:0] RMODE_NEAREST = 2'h0;
    localparam logic [1:0] RMODE_POS_INF = 2'h1;
    localparam logic [1:0] RMODE_NEG_INF = 2'h2;
    localparam logic [1:0] RMODE_ZERO = 2'h3;

    // single-precision field constants
    localparam logic [7:0] EXP_BIAS = 8'h7F;
    localparam logic [7:0] EXP_MAX = 8'hFF;
    localparam logic [7:0] EXP_INT_LSB = 8'h96;
    localparam logic [7:0] EXP_TOO_BIG = 8'h9F;

    // register map, byte offsets
    localparam logic [7:0] REG_PSW = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;

    // reset values
    localparam logic [FLAG_W-1:0] PSW_FLAGS_RST = 6'h00;
    localparam logic [1:0] PSW_RMODE_RST = 2'h0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // interrupt event bits
    localparam int IRQ_W = 2;
    localparam int IRQ_WB_BIT = 0;
    localparam int IRQ_EXC_BIT = 1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic valid;
        logic [2:0] slot;
        logic [7:0] opcode;
        logic guardUsed;
        logic guardLsb;
        logic [31:0] src;
        logic [6:0] dest;
    } fpc_issue_t;

    typedef struct packed {
        logic valid;
        logic [6:0] dest;
        logic [31:0] data;
    } fpc_wb_t;

    typedef struct packed {
        logic valid;
        logic setsPsw;
        logic [FLAG_W-1:0] flags;
        logic [6:0] dest;
        logic [31:0] data;
    } fpc_stage_t;

    typedef struct packed {
        logic [31:0] value;
        logic [FLAG_W-1:0] flags;
    } fpc_conv_t;

endpackage

// ---- fpc_core_model.sv ----
module fpc_core_model
    import fpc_pkg::*;
(
    input wire logic clk_sys, // core clock
    input wire fpc_wb_t wbIn, // write-back from the unit
    output fpc_issue_t issueOut // issue slot drive
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] regFile [128];

    initial issueOut = '0;

    always @(posedge clk_sys) begin
        if (wbIn.valid) begin
            regFile[wbIn.dest] <= wbIn.data;
        end
    end

    // one op per call, so back-to-back calls fill consecutive cycles
    task automatic send(input fpc_issue_t op);
        @(posedge clk_sys);
        issueOut <= op;
    endtask

    // idle slot carries inverted junk so a stale operand is never mistaken for live data
    task automatic idle();
        @(posedge clk_sys);
        issueOut <= {1'b0, ~issueOut[51:0]};
    endtask
endmodule

// ---- tb_fpc_convert_unit.sv ----
module tb_fpc_convert_unit
    import fpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [31:0] due;
        logic [6:0] dest;
        logic [31:0] data;
        logic [FLAG_W-1:0] flg;
    } fpc_exp_t;

    logic clk_sys, rst_n, irq, hsel, hwrite, hready, hreadyout, hresp, inexact_flag, pWr;
    logic [FLAG_W-1:0] otherFlags, pswFlags, expPsw, setF;
    logic [1:0] roundMode, htrans, expRm, expStat, expMask, ev;
    logic [2:0] hsize;
    logic [7:0] pAddr;
    logic [31:0] haddr, hwdata, hrdata, expRd, d, r;
    fpc_issue_t issueIn, op;
    fpc_wb_t wbOut;
    fpc_exp_t e;
    fpc_exp_t q[$];
    int bad_count, tests_run, cyc;
    int seed = 32'h88365AF9;
    logic [31:0] srcs [20] = '{32'h40400000, 32'h40247AE1, 32'hFF4FFFFF, 32'h7F800000,
        32'hBFC147AE, 32'h00400000, 32'h7FC00000, 32'hFFBFFFFF, 32'h80000000, 32'h00000000,
        32'h4F800000, 32'h4F7FFFFF, 32'h3F000000, 32'h00000003, 32'hFFFFFFFF, 32'hFFFFFFFD,
        32'h7FFFFFFF, 32'h7FFFFFF1, 32'h00FFFFFF, 32'h01000001};

    assign hready = hreadyout;

    fpc_core_model core (.clk_sys(clk_sys), .wbIn(wbOut), .issueOut(issueIn));

    fpc_convert_unit i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .issueIn(issueIn),
        .otherFlags(otherFlags), .wbOut(wbOut), .pswFlags(pswFlags), .roundMode(roundMode),
        .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    function automatic logic [31:0] u2f(input logic [31:0] s, input logic [1:0] rm,
                                        output logic x);
        longint ls, keep, rem, half;
        int p;
        x = 1'b0;
        if (s == 32'h0) return 32'h0;
        ls = s;
        p = 31;
        while (ls[p] == 1'b0) p--;
        keep = p <= 23 ? ls << (23 - p) : ls >> (p - 23);
        rem = p <= 23 ? 64'h0 : ls & ((64'h1 << (p - 23)) - 1);
        half = p <= 23 ? 64'h1 : 64'h1 << (p - 24);
        x = rem != 0;
        if (rm == RMODE_NEAREST ? (rem > half || (rem == half && keep[0])) : (rm == RMODE_POS_INF && x))
            keep++;
        // a carry out of the mantissa lands in the exponent field by itself
        return 32'((127 + p) * 64'h800000 + keep - 64'h800000);
    endfunction

    function automatic logic [FLAG_W-1:0] f2uf(input logic [31:0] f);
        int k;
        k = f[30:23];
        if (k == 255) return INVALID_FLAG;
        if (k == 0) return f[22:0] != 0 ? FLUSH_TO_ZERO_FLAG : 6'h00;
        if (f[31] || k >= 159) return INVALID_FLAG;
        if (k < 127) return INEXACT_FLAG;
        if (k >= 150) return 6'h00;
        return (f[22:0] & ((23'h1 << (150 - k)) - 1)) != 0 ? INEXACT_FLAG : 6'h00;
    endfunction

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        check("hresp", hresp, 1'b0);
        if (!wr) check("hrdata", hrdata, expRd);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // reference model, stepped at every edge from the same inputs the unit samples
    always @(posedge clk_sys) begin
        cyc++;
        // whole run needs about 540 cycles
        if (cyc > 3000) begin
            bad_count++;
            finish_test();
        end
        if (rst_n) begin
            setF = otherFlags;
            ev = 2'h0;
            check("pswFlags", pswFlags, expPsw);
            check("roundMode", roundMode, expRm);
            check("irq", irq, |(expStat & expMask));
            if (q.size() > 0 && q[0].due == cyc) begin
                e = q.pop_front();
                check("wbOut", wbOut, {1'b1, e.dest, e.data});
                setF |= e.flg;
                ev = {e.flg != 0, 1'b1};
            end else check("wbOut.valid", wbOut.valid, 1'b0);
            if (issueIn.valid && issueIn.slot inside {SLOT_A, SLOT_B}
                && (!issueIn.guardUsed || issueIn.guardLsb)) begin
                d = u2f(issueIn.src, expRm, inexact_flag);
                if (issueIn.opcode == OP_UFIX_RZ_FLAGS)
                    q.push_back('{cyc + LATENCY, issueIn.dest, {26'h0, f2uf(issueIn.src)}, 6'h00});
                if (issueIn.opcode == OP_UFLOAT)
                    q.push_back('{cyc + LATENCY, issueIn.dest, d, inexact_flag ? INEXACT_FLAG : 6'h00});
                if (issueIn.opcode == OP_UFLOAT_FLAGS)
                    q.push_back('{cyc + LATENCY, issueIn.dest, {26'h0, inexact_flag ? INEXACT_FLAG : 6'h00},
                                  6'h00});
            end
            if (pWr && pAddr == REG_PSW) begin
                expPsw = hwdata[5:0];
                expRm = hwdata[9:8];
            end
            if (pWr && pAddr == REG_IRQ_MASK) expMask = hwdata[1:0];
            pWr = 1'b0;
            if (hsel && hready && htrans[1]) begin
                pWr = hwrite;
                pAddr = haddr[7:0];
                expRd = pAddr == REG_PSW ? {22'h0, expRm, 2'h0, expPsw}
                      : pAddr == REG_IRQ_STATUS ? {30'h0, expStat}
                      : pAddr == REG_IRQ_MASK ? {30'h0, expMask} : 32'h0;
                if (!hwrite && pAddr == REG_IRQ_STATUS) expStat = 2'h0;
            end
            expPsw |= setF;
            expStat |= ev;
        end
    end

    initial begin
        {rst_n, otherFlags, hsel, haddr, htrans, hwrite, hsize, hwdata, pWr} = '0;
        {expPsw, expRm, expStat, expMask} = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b0, REG_PSW, 32'h0);
        ahb(1'b0, REG_IRQ_STATUS, 32'h0);
        ahb(1'b0, REG_IRQ_MASK, 32'h0);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        for (int m = 0; m < 4; m++) begin
            // start from clear flags so that every hardware set is visible
            ahb(1'b1, REG_PSW, {22'h0, m[1:0], 8'h00});
            ahb(1'b0, REG_PSW, 32'h0);
            for (int i = 0; i < 100; i++) begin
                r = $random(seed);
                if (i < 60) begin
                    op = '{1'b1, i[0] ? SLOT_B : SLOT_A, 8'(8'h7E + i / 20), i[1], i % 3 != 0,
                           srcs[i % 20], i[6:0]};
                end else begin
                    op = '{1'b1, r[5:3], 8'(8'h7D + r[1:0] + r[2]), r[6], r[7], $random(seed),
                           r[14:8]};
                    if (r[15]) op.src[30:23] = 8'(8'h7A + r[20:16]);
                end
                core.send(op);
                otherFlags <= r[22:21] == 2'h0 ? r[29:24] : 6'h00;
            end
            core.idle();
            otherFlags <= 6'h00;
            repeat (5) @(posedge clk_sys);
            ahb(1'b0, REG_IRQ_STATUS, 32'h0);
            ahb(1'b1, REG_IRQ_MASK, 32'(m + 1));
            core.send('{1'b1, SLOT_A, OP_UFLOAT, 1'b0, 1'b0, 32'hFFFFFFFF, 7'h05});
            core.idle();
            repeat (5) @(posedge clk_sys);
            ahb(1'b0, REG_IRQ_STATUS, 32'h0);
        end
        finish_test();
    end
endmodule
